/* File: arx_irq.sv */
`timescale 1ns/100ps
module arx_irq #(
    parameter int ADR_W = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // receiver error sources and their update ticks
    input wire logic subframe_tick,
    input wire logic cs_block_tick,
    input wire logic subcode_block_tick,
    input wire logic [7:0] rx_error_src,
    input wire logic rx_in_use,
    // channel status bits, bit n of the block at index n
    input wire logic [39:0] cs_chan_a,
    input wire logic [39:0] cs_chan_b,
    // stream analysis
    input wire logic sample_strobe,
    input wire logic [arx_pkg::SAMPLE_W-1:0] sample_left,
    input wire logic [arx_pkg::SAMPLE_W-1:0] sample_right,
    input wire logic pcm_detect,
    input wire logic burst_detect,
    input wire logic surround_disc_stream,
    input wire logic surround_cd_stream,
    input wire logic high_def_cd_stream,
    input wire logic burst_type_strobe,
    input wire logic [7:0] burst_type_byte,
    // other interrupt sources
    input wire logic output_slip,
    input wire logic out_port_slave,
    input wire logic out_port_async,
    input wire logic cbuf_transfer_done,
    input wire logic subcode_ready,
    input wire logic converter_lock_lost,
    // outputs
    output logic audio_error_hold,
    output logic irq_out
);
    localparam int SAMPLE_W_T = arx_pkg::SAMPLE_W;

    logic [7:0] err_en_q;
    logic [7:0] int_en_q;
    logic [7:0] mode_q;
    logic [7:0] ctrl_q;
    logic [7:0] err_src_q;
    logic [7:0] err_flags_q;
    logic [7:0] int_flags_q;
    logic [7:0] fmt_q;
    logic [7:0] fmt_prev_q;
    logic [79:0] cs_prev_q;
    logic [7:0] burst_prev_q;
    logic [SAMPLE_W_T-1:0] left_prev_q;
    logic [SAMPLE_W_T-1:0] right_prev_q;
    logic [10:0] run_cnt_q;
    logic silence_q;
    logic cs_change_q;
    logic burst_change_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic irq_q;

    logic [5:0] idx;
    logic req_new;
    logic wr_take;
    logic rd_take;
    logic [7:0] int_src;
    logic [7:0] int_evt;
    logic [7:0] summary;
    logic [7:0] fmt_d;
    logic [39:0] cs_sel;
    logic [7:0] read_val;

    assign idx = wb_adr_i[7:2];
    assign req_new = wb_cyc_i & wb_stb_i & ~ack_q;
    // writes act on the edge at which the master sees ack
    assign wr_take = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
    // read-clear happens at capture, so no event between capture and ack is lost
    assign rd_take = req_new & ~wb_we_i;

    // bus slave: one wait state, answer in the cycle after the request
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req_new;
            if (rd_take) begin
                dat_q <= {24'h00_0000, read_val};
            end
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    always_comb begin
        unique case (idx)
            arx_pkg::IDX_RX_ERROR_ENABLE: read_val = err_en_q;
            arx_pkg::IDX_INTERRUPT_ENABLE: read_val = int_en_q;
            arx_pkg::IDX_INTERRUPT_TRIGGER_MODE: read_val = {4'h0, mode_q[3:0]};
            arx_pkg::IDX_RX_CHANNEL_STATUS_SUMMARY: read_val = summary;
            arx_pkg::IDX_STREAM_FORMAT_DETECT: read_val = fmt_q;
            arx_pkg::IDX_RX_ERROR_FLAGS: read_val = err_flags_q;
            arx_pkg::IDX_INTERRUPT_FLAGS: read_val = int_flags_q;
            arx_pkg::IDX_IRQ_CONTROL: read_val = {5'h00, ctrl_q[2:0]};
            default: read_val = 8'h00;
        endcase
    end

    // software registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            err_en_q <= arx_pkg::RST_ENABLE;
            int_en_q <= arx_pkg::RST_ENABLE;
            mode_q <= arx_pkg::RST_MODE;
            ctrl_q <= arx_pkg::RST_CONTROL;
        end else if (wr_take) begin
            unique case (idx)
                arx_pkg::IDX_RX_ERROR_ENABLE: err_en_q <= wb_dat_i[7:0];
                arx_pkg::IDX_INTERRUPT_ENABLE: int_en_q <= wb_dat_i[7:0];
                arx_pkg::IDX_INTERRUPT_TRIGGER_MODE: mode_q <= {4'h0, wb_dat_i[3:0]};
                arx_pkg::IDX_IRQ_CONTROL: ctrl_q <= {5'h00, wb_dat_i[2:0]};
                default: ;
            endcase
        end
    end

    // receiver error sources sampled on their own boundaries
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            err_src_q <= 8'h00;
        end else begin
            if (subcode_block_tick) begin
                err_src_q[arx_pkg::ERR_SUBCODE_CRC] <= rx_error_src[arx_pkg::ERR_SUBCODE_CRC];
            end
            if (cs_block_tick) begin
                // crc is only meaningful for professional blocks
                err_src_q[arx_pkg::ERR_CHAN_CRC] <= rx_error_src[arx_pkg::ERR_CHAN_CRC] & cs_sel[0];
                err_src_q[arx_pkg::ERR_LOCK_LOSS] <= rx_error_src[arx_pkg::ERR_LOCK_LOSS];
            end
            if (subframe_tick) begin
                err_src_q[arx_pkg::ERR_ACTIVITY] <= rx_error_src[arx_pkg::ERR_ACTIVITY];
                err_src_q[3:0] <= rx_error_src[3:0];
            end
        end
    end

    // sticky error flags: set wins over read-clear, a live source re-sets at once
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            err_flags_q <= 8'h00;
        end else begin
            err_flags_q <= ((err_flags_q & ~{8{rd_take && idx == arx_pkg::IDX_RX_ERROR_FLAGS}})
                | err_src_q) & err_en_q;
        end
    end

    // hold policy itself lives downstream; this only says which errors count
    assign audio_error_hold = |(err_src_q & err_en_q & arx_pkg::ERR_SAMPLE_MASK);

    // channel status summary
    assign cs_sel = ctrl_q[arx_pkg::CTRL_CHAN_SEL] ? cs_chan_b : cs_chan_a;

    always_comb begin
        logic pro;
        logic emphasis_flag_ind;
        logic copy_bit;
        logic original_flag_bit;
        logic [3:0] aux;
        pro = cs_sel[0];
        emphasis_flag_ind = pro ? (cs_sel[4:2] == 3'b011) : cs_sel[3];
        aux = (pro && cs_sel[18:16] == 3'b001) ? arx_pkg::AUX_FOUR : arx_pkg::AUX_NONE;
        copy_bit = (cs_sel[15:8] == arx_pkg::CATEGORY_GENERAL) ? 1'b0 : cs_sel[2];
        original_flag_bit = cs_sel[15];
        if (pro || !rx_in_use) begin
            copy_bit = 1'b1;
            original_flag_bit = 1'b1;
        end
        summary = {aux, pro, copy_bit, original_flag_bit, ~emphasis_flag_ind};
    end

    // digital silence: run of identical samples, saturating
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            left_prev_q <= '0;
            right_prev_q <= '0;
            run_cnt_q <= 11'h000;
            silence_q <= 1'b0;
        end else if (sample_strobe) begin
            left_prev_q <= sample_left;
            right_prev_q <= sample_right;
            if (sample_left == left_prev_q && sample_right == right_prev_q) begin
                if (run_cnt_q != 11'(arx_pkg::SILENCE_RUN)) begin
                    run_cnt_q <= run_cnt_q + 11'h001;
                end
                silence_q <= (run_cnt_q + 11'h001) >= 11'(arx_pkg::SILENCE_RUN)
                    || run_cnt_q == 11'(arx_pkg::SILENCE_RUN);
            end else begin
                run_cnt_q <= 11'h001;
                silence_q <= 1'b0;
            end
        end
    end

    // format flags, the stream types in bits 7 to 4 in a fixed priority so at most one of them is set; bit 3 is independent
    always_comb begin
        fmt_d = 8'h00;
        fmt_d[6] = burst_detect;
        fmt_d[5] = surround_disc_stream & ~burst_detect;
        fmt_d[4] = surround_cd_stream & ~burst_detect & ~surround_disc_stream;
        fmt_d[7] = pcm_detect & ~burst_detect & ~surround_disc_stream & ~surround_cd_stream;
        fmt_d[3] = high_def_cd_stream;
        fmt_d[2] = silence_q;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            fmt_q <= 8'h00;
            fmt_prev_q <= 8'h00;
        end else begin
            fmt_q <= fmt_d;
            fmt_prev_q <= fmt_q;
        end
    end

    // channel status and burst type comparison
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cs_prev_q <= 80'h0;
            cs_change_q <= 1'b0;
            burst_prev_q <= 8'h00;
            burst_change_q <= 1'b0;
        end else begin
            cs_change_q <= 1'b0;
            burst_change_q <= 1'b0;
            if (cs_block_tick) begin
                cs_prev_q <= {cs_chan_b, cs_chan_a};
                cs_change_q <= {cs_chan_b, cs_chan_a} != cs_prev_q;
            end
            if (burst_type_strobe) begin
                burst_prev_q <= burst_type_byte;
                burst_change_q <= burst_type_byte != burst_prev_q;
            end
        end
    end

    // interrupt conditions; only the receiver error and converter sources see a mode
    always_comb begin
        int_src = 8'h00;
        int_src[arx_pkg::INT_BURST_TYPE_CHANGE] = burst_change_q | (fmt_q[6] & ~fmt_prev_q[6]);
        int_src[arx_pkg::INT_OUTPUT_SLIP] = output_slip & out_port_slave & out_port_async;
        int_src[arx_pkg::INT_CBUF_DONE] = cbuf_transfer_done;
        int_src[arx_pkg::INT_CHAN_STATUS_CHANGE] = cs_change_q;
        int_src[arx_pkg::INT_RX_ERROR] = |err_flags_q;
        int_src[arx_pkg::INT_SUBCODE_READY] = subcode_ready;
        int_src[arx_pkg::INT_FORMAT_CHANGE] = |({fmt_q[7:4], fmt_q[2]} & ~{fmt_prev_q[7:4], fmt_prev_q[2]});
        int_src[arx_pkg::INT_CONVERTER_LOCK] = converter_lock_lost;
    end

    for (genvar i = 0; i < 8; i++) begin : g_evt
        arx_pkg::arx_trig_t m;
        if (i == arx_pkg::INT_RX_ERROR) begin : g_rx_error_summary
            assign m = arx_pkg::arx_trig_t'(mode_q[arx_pkg::MODE_RX_ERR_LSB +: 2]);
        end else if (i == arx_pkg::INT_CONVERTER_LOCK) begin : g_conv
            assign m = arx_pkg::arx_trig_t'(mode_q[arx_pkg::MODE_CONV_LSB +: 2]);
        end else begin : g_fixed
            assign m = arx_pkg::ARX_TRIG_RISE;
        end
        arx_evt u_evt (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .cond(int_src[i]),
            .mode(m),
            .evt(int_evt[i])
        );
    end

    // level sources keep their flag because the level event re-sets it over a clear
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            int_flags_q <= 8'h00;
        end else begin
            int_flags_q <= ((int_flags_q & ~{8{rd_take && idx == arx_pkg::IDX_INTERRUPT_FLAGS}})
                | int_evt) & int_en_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (|int_flags_q) ^ (ctrl_q[arx_pkg::CTRL_POL_LSB +: 2] == arx_pkg::POL_ACTIVE_LOW);
        end
    end
    assign irq_out = irq_q;

    a_ack_single: assert property (@(posedge sys_clk) disable iff (!rstn)
        wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
    a_ack_latency: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack not one cycle after request");
    a_enables_reset: assert property (@(posedge sys_clk)
        !rstn |=> (err_en_q == 8'h00 && int_en_q == 8'h00)) else $error("enables not cleared by reset");
    a_err_masked_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        ##1 (err_flags_q & ~$past(err_en_q)) == 8'h00) else $error("disabled error flag is set");
    a_int_masked_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        ##1 (int_flags_q & ~$past(int_en_q)) == 8'h00) else $error("masked interrupt flag is set");
    a_fall_mode_fires: assert property (@(posedge sys_clk) disable iff (!rstn)
        (int_en_q[0] && mode_q[1:0] == 2'b01 && $fell(converter_lock_lost)) |=> int_flags_q[0])
        else $error("falling mode did not flag on removal");
    a_rise_mode_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
        (int_flags_q[2] == 1'b0 && !subcode_ready) |=> !int_flags_q[2]) else $error("flag set without event");
    a_silence_count: assert property (@(posedge sys_clk) disable iff (!rstn)
        silence_q |-> run_cnt_q == 11'h7FF) else $error("silence flagged before full run");
    a_format_onehot: assert property (@(posedge sys_clk) disable iff (!rstn)
        $onehot0({fmt_q[7:4]})) else $error("stream flags not exclusive");
    a_irq_shape: assert property (@(posedge sys_clk) disable iff (!rstn)
        ##1 irq_out == ($past(|int_flags_q) ^ ($past(ctrl_q[2:1]) == 2'b01))) else $error("irq output mismatch");
    a_copy_pro: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cs_sel[0] || !rx_in_use) |-> (summary[2] && summary[1])) else $error("copy or original not forced");
    a_sample_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        ((err_src_q & err_en_q & 8'h1F) == 8'h00) |-> !audio_error_hold) else $error("crc or activity held audio");
    a_slip_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
        (output_slip && out_port_slave && out_port_async && int_en_q[6]) |=> ##1 int_flags_q[6])
        else $error("slip not flagged");

    c_read_clear: cover property (@(posedge sys_clk) disable iff (!rstn)
        rd_take && idx == arx_pkg::IDX_INTERRUPT_FLAGS && int_flags_q != 8'h00);
    c_level_persist: cover property (@(posedge sys_clk) disable iff (!rstn)
        mode_q[3:2] == 2'b10 && int_flags_q[3] ##1 int_flags_q[3]);
    c_silence: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(silence_q));
endmodule // arx_irq

/* File: arx_pkg.sv */
package arx_pkg;
    // register indices; the byte address on the bus is four times the index
    localparam logic [5:0] IDX_RX_ERROR_ENABLE = 6'h0E;
    localparam logic [5:0] IDX_INTERRUPT_ENABLE = 6'h0F;
    localparam logic [5:0] IDX_INTERRUPT_TRIGGER_MODE = 6'h10;
    localparam logic [5:0] IDX_RX_CHANNEL_STATUS_SUMMARY = 6'h11;
    localparam logic [5:0] IDX_STREAM_FORMAT_DETECT = 6'h12;
    localparam logic [5:0] IDX_RX_ERROR_FLAGS = 6'h13;
    localparam logic [5:0] IDX_INTERRUPT_FLAGS = 6'h14;
    localparam logic [5:0] IDX_IRQ_CONTROL = 6'h31;

    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;

    // rx error flag positions
    localparam int ERR_ACTIVITY = 7;
    localparam int ERR_SUBCODE_CRC = 6;
    localparam int ERR_CHAN_CRC = 5;
    localparam int ERR_LOCK_LOSS = 4;
    localparam int ERR_VALIDITY = 3;
    localparam int ERR_CONFIDENCE = 2;
    localparam int ERR_BIPHASE = 1;
    localparam int ERR_PARITY = 0;
    // errors that may touch the audio sample
    localparam logic [7:0] ERR_SAMPLE_MASK = 8'h1F;

    // interrupt flag positions
    localparam int INT_BURST_TYPE_CHANGE = 7;
    localparam int INT_OUTPUT_SLIP = 6;
    localparam int INT_CBUF_DONE = 5;
    localparam int INT_CHAN_STATUS_CHANGE = 4;
    localparam int INT_RX_ERROR = 3;
    localparam int INT_SUBCODE_READY = 2;
    localparam int INT_FORMAT_CHANGE = 1;
    localparam int INT_CONVERTER_LOCK = 0;

    // mode field positions and the irq control fields
    localparam int MODE_RX_ERR_LSB = 2;
    localparam int MODE_CONV_LSB = 0;
    localparam int CTRL_CHAN_SEL = 0;
    localparam int CTRL_POL_LSB = 1;

    typedef enum logic [1:0] {
        ARX_TRIG_RISE = 2'b00,
        ARX_TRIG_FALL = 2'b01,
        ARX_TRIG_LEVEL = 2'b10,
        ARX_TRIG_RSVD = 2'b11
    } arx_trig_t;

    // polarity code that makes the interrupt output active low
    localparam logic [1:0] POL_ACTIVE_LOW = 2'b01;

    localparam int SILENCE_RUN = 2047;
    localparam int SAMPLE_W = 24;
    localparam logic [7:0] CATEGORY_GENERAL = 8'h00;
    localparam logic [3:0] AUX_NONE = 4'h0;
    localparam logic [3:0] AUX_FOUR = 4'h4;
endpackage

/* File: arx_evt.sv */
`timescale 1ns/100ps
// turns a condition into an event according to the trigger mode
module arx_evt (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // condition and mode
    input wire logic cond,
    input wire arx_pkg::arx_trig_t mode,
    // event
    output logic evt
);
    logic cond_q;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cond_q <= 1'b0;
        end else begin
            cond_q <= cond;
        end
    end

    always_comb begin
        unique case (mode)
            arx_pkg::ARX_TRIG_RISE: evt = cond & ~cond_q;
            arx_pkg::ARX_TRIG_FALL: evt = ~cond & cond_q;
            arx_pkg::ARX_TRIG_LEVEL: evt = cond;
            arx_pkg::ARX_TRIG_RSVD: evt = 1'b0;
        endcase
    end
endmodule // arx_evt

/* File: arx_src_model.sv */
`timescale 1ns/100ps
// receiver side: boundary strobes of the incoming stream
module arx_src_model #(
    parameter int SF_DIV = 4,
    parameter int BLK_DIV = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // boundary strobes
    output logic subframe_tick,
    output logic cs_block_tick,
    output logic subcode_block_tick
);
    int cyc_q;
    int sf_q;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cyc_q <= 0;
            sf_q <= 0;
        end else begin
            cyc_q <= (cyc_q == SF_DIV - 1) ? 0 : cyc_q + 1;
            if (cyc_q == SF_DIV - 1) begin
                sf_q <= (sf_q == BLK_DIV - 1) ? 0 : sf_q + 1;
            end
        end
    end
    // blocks are far shorter than real ones so block updates show within a few dozen cycles
    assign subframe_tick = rstn && cyc_q == SF_DIV - 1;
    assign cs_block_tick = subframe_tick && sf_q == BLK_DIV - 1;
    assign subcode_block_tick = cs_block_tick;
endmodule // arx_src_model

/* File: arx_irq_test.sv */
`timescale 1ns/100ps
module arx_irq_test;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, audio_error_hold, irq_out, sf_t, cs_t, sc_t;
    logic [7:0] rx_error_src = 8'h00;
    logic rx_in_use = 1'b1, sample_strobe = 1'b0, lock_lost = 1'b0, slave = 1'b1, async_clk = 1'b1;
    logic [39:0] cs_a = 40'h0000000000, cs_b = 40'h0000000000;
    logic [23:0] smp_l = 24'h5A5A5A, smp_r = 24'hA5A5A5;
    logic [4:0] fmt = 5'h00;
    logic [3:0] pls = 4'h0;
    logic [7:0] burst_byte = 8'hA5;
    logic [7:0] pexp [4] = '{8'h04, 8'h20, 8'h40, 8'h80};
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;

    arx_src_model i_arx_src_model (.sys_clk(sys_clk), .rstn(rstn), .subframe_tick(sf_t), .cs_block_tick(cs_t),
        .subcode_block_tick(sc_t));
    arx_irq i_arx_irq (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .subframe_tick(sf_t), .cs_block_tick(cs_t), .subcode_block_tick(sc_t), .rx_error_src(rx_error_src),
        .rx_in_use(rx_in_use), .cs_chan_a(cs_a), .cs_chan_b(cs_b), .sample_strobe(sample_strobe),
        .sample_left(smp_l), .sample_right(smp_r), .pcm_detect(fmt[4]), .burst_detect(fmt[3]),
        .surround_disc_stream(fmt[2]), .surround_cd_stream(fmt[1]), .high_def_cd_stream(fmt[0]),
        .burst_type_strobe(pls[3]), .burst_type_byte(burst_byte), .output_slip(pls[2]), .out_port_slave(slave),
        .out_port_async(async_clk), .cbuf_transfer_done(pls[1]), .subcode_ready(pls[0]),
        .converter_lock_lost(lock_lost), .audio_error_hold(audio_error_hold), .irq_out(irq_out));

    always #10 sys_clk = ~sys_clk;

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // the whole run is under 20000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
            n_errors++;
        end
    endtask

    task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] rdat);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, wd};
        // only the bench timeout ends a wait for ack
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] e, input string nm);
        logic [7:0] x;
        bus(1'b0, idx, 8'h00, x);
        chk8(nm, e, x);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic pulse(input int i);
        @(posedge sys_clk);
        pls <= 4'(1 << i);
        @(posedge sys_clk);
        pls <= 4'h0;
    endtask

    task automatic strobes(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            sample_strobe <= 1'b1;
            @(posedge sys_clk);
            sample_strobe <= 1'b0;
        end
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(arx_pkg::IDX_RX_ERROR_ENABLE, 8'h00, "err_en");
        rd(arx_pkg::IDX_INTERRUPT_ENABLE, 8'h00, "int_en");
        rd(arx_pkg::IDX_INTERRUPT_TRIGGER_MODE, 8'h00, "mode");
        rd(6'h3F, 8'h00, "unmapped");
        pulse(0);
        idle(4);
        chk1("irq masked", 1'b0, irq_out);
        rd(arx_pkg::IDX_INTERRUPT_FLAGS, 8'h00, "int masked");
        wr(arx_pkg::IDX_RX_ERROR_ENABLE, 8'h81);
        rd(arx_pkg::IDX_RX_ERROR_ENABLE, 8'h81, "err_en");
        wr(arx_pkg::IDX_INTERRUPT_ENABLE, 8'hFF);
        wr(arx_pkg::IDX_INTERRUPT_TRIGGER_MODE, 8'h00);
        // activity error enabled, validity error left disabled
        rx_error_src <= 8'h88;
        idle(20);
        chk1("hold activity", 1'b0, audio_error_hold);
        rx_error_src <= 8'h00;
        idle(10);
        rd(arx_pkg::IDX_INTERRUPT_FLAGS, 8'h08, "int rx err");
        rd(arx_pkg::IDX_RX_ERROR_FLAGS, 8'h80, "err flags");
        rd(arx_pkg::IDX_RX_ERROR_FLAGS, 8'h00, "err cleared");
        rx_error_src <= 8'h01;
        idle(20);
        chk1("hold parity", 1'b1, audio_error_hold);
        chk1("irq rx err", 1'b1, irq_out);
        rx_error_src <= 8'h00;
        idle(10);
        rd(arx_pkg::IDX_RX_ERROR_FLAGS, 8'h01, "err parity");
        rd(arx_pkg::IDX_INTERRUPT_FLAGS, 8'h08, "int parity");
        idle(3);
        chk1("irq cleared", 1'b0, irq_out);
        // parity masked again so that only the activity error feeds the receiver error summary in level mode
        wr(arx_pkg::IDX_RX_ERROR_ENABLE, 8'h80);
        wr(arx_pkg::IDX_INTERRUPT_TRIGGER_MODE, 8'h08);
        rx_error_src <= 8'h80;
        idle(10);
        rd(arx_pkg::IDX_INTERRUPT_FLAGS, 8'h08, "rx_error_summary level");
        rd(arx_pkg::IDX_INTERRUPT_FLAGS, 8'h08, "rx_error_summary level held");
        rx_error_src <= 8'h00;
        idle(10);
        rd(arx_pkg::IDX_RX_ERROR_FLAGS, 8'h80, "err activity");
        idle(2);
        rd(arx_pkg::IDX_INTERRUPT_FLAGS, 8'h08, "rx_error_summary level end");
        rd(arx_pkg::IDX_INTERRUPT_FLAGS, 8'h00, "rx_error_summary level clr");
        wr(arx_pkg::IDX_INTERRUPT_TRIGGER_MODE, 8'h00);
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            idle(4);
            chk1("irq pulse", 1'b1, irq_out);
            rd(arx_pkg::IDX_INTERRUPT_FLAGS, pexp[i], "int pulse");
            idle(3);
            chk1("irq after read", 1'b0, irq_out);
        end
        slave <= 1'b0;
        pulse(2);
        idle(4);
        rd(arx_pkg::IDX_INTERRUPT_FLAGS, 8'h00, "slip master");
        for (int k = 0; k < 4; k++) begin
            wr(arx_pkg::IDX_INTERRUPT_TRIGGER_MODE, {6'h00, 2'(k)});
            rd(arx_pkg::IDX_INTERRUPT_TRIGGER_MODE, {6'h00, 2'(k)}, "mode");
            lock_lost <= 1'b1;
            idle(8);
            rd(arx_pkg::IDX_INTERRUPT_FLAGS, {7'h00, k == 0 || k == 2}, "unlock on");
            rd(arx_pkg::IDX_INTERRUPT_FLAGS, {7'h00, k == 2}, "unlock held");
            lock_lost <= 1'b0;
            idle(8);
            rd(arx_pkg::IDX_INTERRUPT_FLAGS, {7'h00, k == 1 || k == 2}, "unlock off");
        end
        for (int i = 0; i < 5; i++) begin
            fmt <= 5'h10 >> i;
            idle(6);
            rd(arx_pkg::IDX_STREAM_FORMAT_DETECT, 8'h80 >> i, "format");
            rd(arx_pkg::IDX_INTERRUPT_FLAGS, (i == 1) ? 8'h82 : ((i == 4) ? 8'h00 : 8'h02), "fmt rise");
            fmt <= 5'h00;
            idle(6);
            rd(arx_pkg::IDX_INTERRUPT_FLAGS, 8'h00, "fmt fall");
        end
        fmt <= 5'h1C;
        idle(6);
        rd(arx_pkg::IDX_STREAM_FORMAT_DETECT, 8'h40, "exclusive");
        rd(arx_pkg::IDX_INTERRUPT_FLAGS, 8'h82, "burst rise");
        fmt <= 5'h00;
        strobes(2046);
        idle(3);
        rd(arx_pkg::IDX_STREAM_FORMAT_DETECT, 8'h00, "silence 2046");
        strobes(1);
        idle(3);
        rd(arx_pkg::IDX_STREAM_FORMAT_DETECT, 8'h04, "silence 2047");
        rd(arx_pkg::IDX_INTERRUPT_FLAGS, 8'h02, "silence fmt");
        // channel A: professional, emphasis code 011, aux code 001
        cs_a <= 40'h000001000D;
        idle(40);
        rd(arx_pkg::IDX_RX_CHANNEL_STATUS_SUMMARY, 8'h4E, "summary A");
        rd(arx_pkg::IDX_INTERRUPT_FLAGS, 8'h10, "cs change");
        wr(arx_pkg::IDX_IRQ_CONTROL, 8'h01);
        idle(4);
        rd(arx_pkg::IDX_RX_CHANNEL_STATUS_SUMMARY, 8'h01, "summary B");
        rx_in_use <= 1'b0;
        idle(4);
        rd(arx_pkg::IDX_RX_CHANNEL_STATUS_SUMMARY, 8'h07, "summary unused");
        wr(arx_pkg::IDX_IRQ_CONTROL, {5'h00, arx_pkg::POL_ACTIVE_LOW, 1'b1});
        idle(3);
        chk1("irq idle low pol", 1'b1, irq_out);
        pulse(0);
        idle(4);
        chk1("irq active low", 1'b0, irq_out);
        rd(arx_pkg::IDX_INTERRUPT_FLAGS, 8'h04, "int pol");
        // second reset in mid-run: written registers must return to zero
        rstn <= 1'b0;
        idle(2);
        rstn <= 1'b1;
        rd(arx_pkg::IDX_RX_ERROR_ENABLE, 8'h00, "err_en reset");
        rd(arx_pkg::IDX_INTERRUPT_ENABLE, 8'h00, "int_en reset");
        chk1("irq reset", 1'b0, irq_out);
        summarize();
    end
endmodule // arx_irq_test
